//--- src/buffer_dma_controller.sv
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module buffer_dma_controller
(
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rst_n,
  // register slave
  input  wire logic [dma_pkg::REG_ADDR_W-1:0]      avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [dma_pkg::BUS_DATA_W-1:0]      avs_writedata,
  output logic      [dma_pkg::BUS_DATA_W-1:0]      avs_readdata,
  output logic                                     avs_waitrequest,
  // channel clients
  input  wire logic [dma_pkg::NUM_CH-1:0]          chReqPin,
  output logic      [dma_pkg::NUM_CH-1:0]          chAckPin,
  input  wire logic [dma_pkg::NUM_CH-1:0][7:0]     chWriteData,
  output logic      [dma_pkg::BYTE_W-1:0]          chReadData,
  // buffer memory
  output dma_pkg::memBus_type                      memBus,
  input  wire logic [dma_pkg::BYTE_W-1:0]          memRdData,
  // external register strobes
  output logic      [dma_pkg::EXT_REGS-1:0]        extReadStrobe,
  output logic      [dma_pkg::EXT_REGS-1:0]        extWriteStrobe,
  // interrupt
  output logic                                     irq
);
  import dma_pkg::*;

  // lowest set bit wins
  function automatic logic [1:0] firstOne(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[0])
      r = 2'h0;
    else if (v[1])
      r = 2'h1;
    else if (v[2])
      r = 2'h2;
    else if (v[3])
      r = 2'h3;
    return r;
  endfunction

  // channel number of a register index in the channel blocks
  function automatic logic [1:0] regChan(input logic [4:0] a);
    logic [2:0] d;
    d = a[4:2] - 3'h2;
    return d[1:0];
  endfunction

  // channel state
  logic [15:0]     addr_q    [NUM_CH];
  logic [15:0]     count_q   [NUM_CH];
  logic [15:0]     init_q    [NUM_CH];
  chCtrl_type      ctrl_q    [NUM_CH];
  logic [3:0]      release_q;
  // global registers
  logic [7:0]      cycle_q;
  logic [7:0]      extCtrl_q;
  logic [3:0]      irqStat_q;
  logic [3:0]      irqMask_q;
  // sequencer
  dmaState_type    state_q;
  logic [1:0]      cur_q;
  logic [WAIT_W-1:0] wait_q;
  // outputs
  logic [31:0]     readData_q;
  logic            waitReq_q;
  logic [3:0]      ack_q;
  logic [7:0]      rdByte_q;
  memBus_type      mem_q;
  logic [7:0]      extRd_q;
  logic [7:0]      extWr_q;
  logic            irq_q;

  // request conditioning per channel
  logic [3:0] reqAct;
  logic [3:0] reqLowVec;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_req
      assign reqLowVec[gi] = ctrl_q[gi].reqLow;
      dma_req_sync u_sync
      (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .reqPin    (chReqPin[gi]),
        .activeLow (reqLowVec[gi]),
        .reqActive (reqAct[gi])
      );
    end
  endgenerate

  // eligibility and arbitration
  logic [3:0] eligible;
  logic [3:0] enVec;
  logic [3:0] bigVec;
  logic [3:0] ackLowVec;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_elig
      assign enVec[gi]    = ctrl_q[gi].enable;
      assign bigVec[gi]   = count_q[gi] > COUNT_THRESHOLD;
      assign ackLowVec[gi] = ctrl_q[gi].ackLow;
      assign eligible[gi] = enVec[gi] & reqAct[gi] & ~release_q[gi]
                            & (count_q[gi] != 16'h0000);
    end
  endgenerate
  wire logic [1:0] pick    = firstOne(eligible);
  wire logic       anyElig = |eligible;

  // current channel and its handshake style
  wire chCtrl_type curCtrl   = ctrl_q[cur_q];
  wire logic       tapeMode  = curCtrl.special & (cur_q == CH_TAPE);
  wire logic       hostMode  = curCtrl.special & (cur_q == CH_HOST);
  wire logic       interlock = tapeMode | hostMode;
  wire logic       memDone   = (state_q == ST_MEM) && (wait_q == '0);
  wire logic [15:0] nextCount = count_q[cur_q] - 16'h0001;
  wire logic       chanEnd   = memDone && (nextCount == 16'h0000);
  wire logic [3:0] curHot    = 4'h1 << cur_q;

  // bus handshake decode
  wire logic       busReq   = avs_read | avs_write;
  wire logic       busTake  = busReq & waitReq_q;
  wire logic       busDone  = busReq & ~waitReq_q;
  wire logic       wrDone   = busDone & avs_write;
  wire logic       chReg    = (avs_address >= REG_CH_BASE) && (avs_address < REG_CH_LIMIT);
  wire logic [1:0] regCh    = regChan(avs_address);
  wire logic [1:0] regWord  = avs_address[1:0];

  // read data selection
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (avs_address == REG_CH_STATUS)
      rdMux = {24'h00_0000, bigVec, enVec};
    else if (avs_address == REG_IRQ_STATUS)
      rdMux = {28'h000_0000, irqStat_q};
    else if (avs_address == REG_IRQ_MASK)
      rdMux = {28'h000_0000, irqMask_q};
    else if (chReg && regWord == CH_ADDR_OFS)
      rdMux = {16'h0000, addr_q[regCh]};
    else if (chReg && regWord == CH_COUNT_OFS)
      rdMux = {16'h0000, count_q[regCh]};
    else if (chReg && regWord == CH_CTRL_OFS)
      rdMux = {24'h00_0000, ctrl_q[regCh]};
  end

  // slave answer: one wait cycle, data latched as waitrequest falls
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitReq_q  <= 1'b1;
      readData_q <= 32'h0000_0000;
    end
    else
    begin
      waitReq_q <= ~busTake;
      if (busTake)
        readData_q <= avs_read ? rdMux : 32'h0000_0000;
    end
  end

  // global control registers, written only from software; cycle time and external control do not read back, the mask does
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cycle_q   <= CYCLE_RESET;
      extCtrl_q <= EXT_RESET;
      irqMask_q <= MASK_RESET;
    end
    else if (wrDone)
    begin
      if (avs_address == REG_CYCLE_TIME)
        cycle_q <= avs_writedata[7:0];
      else if (avs_address == REG_EXT_CTRL)
        extCtrl_q <= avs_writedata[7:0];
      else if (avs_address == REG_IRQ_MASK)
        irqMask_q <= avs_writedata[3:0];
    end
  end

  // external register strobes, one cycle after the load
  wire logic       extLoad = wrDone && (avs_address == REG_EXT_CTRL);
  wire logic [7:0] extHot  = 8'h01 << avs_writedata[EXT_SEL_LSB +: 3];
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extRd_q <= 8'h00;
      extWr_q <= 8'h00;
    end
    else
    begin
      extRd_q <= (extLoad && !avs_writedata[EXT_WRITE_BIT]) ? extHot : 8'h00;
      extWr_q <= (extLoad && avs_writedata[EXT_WRITE_BIT]) ? extHot : 8'h00;
    end
  end

  // per channel registers; a software write wins over the transfer update
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_chan
      wire logic swHit = wrDone && chReg && (regCh == 2'(gi));
      wire logic hwHit = memDone && (cur_q == 2'(gi));
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          addr_q[gi]  <= ADDR_RESET;
          count_q[gi] <= COUNT_RESET;
          init_q[gi]  <= COUNT_RESET;
          ctrl_q[gi]  <= CTRL_RESET;
        end
        else if (swHit)
        begin
          if (regWord == CH_ADDR_OFS)
            addr_q[gi] <= avs_writedata[15:0];
          else if (regWord == CH_COUNT_OFS)
          begin
            count_q[gi] <= avs_writedata[15:0];
            init_q[gi]  <= avs_writedata[15:0];
          end
          else if (regWord == CH_CTRL_OFS)
            ctrl_q[gi] <= avs_writedata[7:0];
        end
        else if (hwHit)
        begin
          addr_q[gi] <= addr_q[gi] + 16'h0001;
          if (nextCount == 16'h0000 && ctrl_q[gi].reinit)
            count_q[gi] <= init_q[gi];
          else
            count_q[gi] <= nextCount;
        end
      end
    end
  endgenerate

  // transfer sequencer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      cur_q   <= 2'h0;
      wait_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (anyElig)
          begin
            state_q <= ST_MEM;
            cur_q   <= pick;
            wait_q  <= cycle_q[CYC_WAIT_LSB +: WAIT_W];
          end
        ST_MEM:
          if (wait_q == '0)
            state_q <= ST_ACK;
          else
            wait_q <= wait_q - 1'b1;
        ST_ACK:
          state_q <= interlock ? ST_RELEASE : ST_IDLE;
        ST_RELEASE:
          if (!reqAct[cur_q])
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // a served request must fall before the channel may be granted again
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      release_q <= 4'h0;
    else
      release_q <= (release_q & reqAct) | ((state_q == ST_ACK) ? curHot : 4'h0);
  end

  // buffer memory strobes, held for the whole programmed cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_q    <= '0;
      rdByte_q <= 8'h00;
    end
    else if (state_q == ST_IDLE && anyElig)
    begin
      mem_q.rd    <= ~ctrl_q[pick].bufWrite;
      mem_q.wr    <= ctrl_q[pick].bufWrite;
      mem_q.addr  <= addr_q[pick];
      mem_q.wdata <= chWriteData[pick];
    end
    else if (memDone)
    begin
      mem_q.rd <= 1'b0;
      mem_q.wr <= 1'b0;
      if (!curCtrl.bufWrite)
        rdByte_q <= memRdData;
    end
  end

  // acknowledge: generic covers the memory cycle, byte handshakes hold it to release
  wire logic ackOn = ((state_q == ST_MEM) && !interlock) || (state_q == ST_ACK)
                     || (state_q == ST_RELEASE);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 4'h0;
    else
      ack_q <= (ackOn ? curHot : 4'h0) ^ ackLowVec;
  end

  // channel end with irqEn sets sticky status; set wins over the read clear
  wire logic       stClr   = busDone && avs_read && (avs_address == REG_IRQ_STATUS);
  wire logic [3:0] endEvt  = (chanEnd && curCtrl.irqEn) ? curHot : 4'h0;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqStat_q <= 4'h0;
      irq_q     <= 1'b0;
    end
    else
    begin
      irqStat_q <= (stClr ? 4'h0 : irqStat_q) | endEvt;
      irq_q     <= (|(irqStat_q & irqMask_q)) ^ cycle_q[IRQ_POL_BIT];
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata    = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign chAckPin        = ack_q;
  assign chReadData      = rdByte_q;
  assign memBus          = mem_q;
  assign extReadStrobe   = extRd_q;
  assign extWriteStrobe  = extWr_q;
  assign irq             = irq_q;

endmodule

//--- src/dma_pkg.sv
package dma_pkg;

  // channel and bus geometry
  localparam int NUM_CH     = 4;
  localparam int MEM_ADDR_W = 16;
  localparam int BYTE_W     = 8;
  localparam int REG_ADDR_W = 5;
  localparam int BUS_DATA_W = 32;
  localparam int EXT_REGS   = 8;
  localparam int WAIT_W     = 4;

  // register word indices on the slave port
  localparam logic [4:0] REG_CH_STATUS  = 5'h00;
  localparam logic [4:0] REG_CYCLE_TIME = 5'h01;
  localparam logic [4:0] REG_EXT_CTRL   = 5'h02;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h03;
  localparam logic [4:0] REG_IRQ_MASK   = 5'h04;
  localparam logic [4:0] REG_CH_BASE    = 5'h08;
  localparam logic [4:0] REG_CH_LIMIT   = 5'h18;

  // word within a channel's block of four
  localparam logic [1:0] CH_ADDR_OFS  = 2'h0;
  localparam logic [1:0] CH_COUNT_OFS = 2'h1;
  localparam logic [1:0] CH_CTRL_OFS  = 2'h2;

  // field positions
  localparam int CYC_WAIT_LSB  = 0;
  localparam int IRQ_POL_BIT   = 7;
  localparam int EXT_SEL_LSB   = 0;
  localparam int EXT_WRITE_BIT = 3;
  localparam int STAT_EN_LSB   = 0;
  localparam int STAT_BIG_LSB  = 4;

  // channel numbers of the two special handshakes
  localparam logic [1:0] CH_TAPE = 2'h1;
  localparam logic [1:0] CH_HOST = 2'h2;

  // status threshold on the remaining byte count
  localparam logic [15:0] COUNT_THRESHOLD = 16'h0081;

  // reset values
  localparam logic [7:0]  CYCLE_RESET = 8'h00;
  localparam logic [7:0]  EXT_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [3:0]  MASK_RESET  = 4'h0;

  // per channel control byte
  typedef struct packed {
    logic reserved;
    logic special;
    logic ackLow;
    logic reqLow;
    logic irqEn;
    logic reinit;
    logic bufWrite;
    logic enable;
  } chCtrl_type;

  // buffer memory port
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } memBus_type;

  // transfer sequencer, gray along idle-mem-ack-release
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_MEM     = 2'b01,
    ST_ACK     = 2'b11,
    ST_RELEASE = 2'b10
  } dmaState_type;

endpackage

//--- src/dma_req_sync.sv
`timescale 1ns/1ps
module dma_req_sync
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // request pin and its programmed polarity
  input  wire logic reqPin,
  input  wire logic activeLow,
  // request seen as a clean active-high level
  output logic      reqActive
);

  logic syncA_q;
  logic syncB_q;
  logic syncC_q;
  logic stable_q;

  // three stage synchroniser; the level moves only when stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q  <= 1'b0;
      syncB_q  <= 1'b0;
      syncC_q  <= 1'b0;
      stable_q <= 1'b0;
    end
    else
    begin
      syncA_q <= reqPin;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      if (syncB_q == syncC_q)
        stable_q <= syncC_q;
    end
  end

  // per channel polarity
  assign reqActive = stable_q ^ activeLow;

endmodule

//--- dv/buffer_dma_controller_assertions.sv
`timescale 1ns/1ps
module buffer_dma_controller_assertions
(
  // clock and reset
  input wire logic                           sys_clk,
  input wire logic                           rst_n,
  // register slave
  input wire logic [dma_pkg::REG_ADDR_W-1:0] avs_address,
  input wire logic                           avs_read,
  input wire logic                           avs_write,
  input wire logic [dma_pkg::BUS_DATA_W-1:0] avs_writedata,
  input wire logic                           avs_waitrequest,
  // memory and strobes
  input wire dma_pkg::memBus_type            memBus,
  input wire logic [dma_pkg::EXT_REGS-1:0]   extReadStrobe,
  input wire logic [dma_pkg::EXT_REGS-1:0]   extWriteStrobe
);
  import dma_pkg::*;
  logic       memBusy;
  logic [4:0] memLen_q;
  logic [3:0] cycTime_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // length of the running memory cycle and the programmed cycle time
  assign memBusy = memBus.rd | memBus.wr;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memLen_q  <= 5'h00;
      cycTime_q <= 4'h0;
    end
    else
    begin
      memLen_q <= memBusy ? memLen_q + 5'h01 : 5'h00;
      if (avs_write && !avs_waitrequest && avs_address == REG_CYCLE_TIME)
        cycTime_q <= avs_writedata[3:0];
    end
  end
  sequence s_extDone;
    avs_write && !avs_waitrequest && avs_address == REG_EXT_CTRL;
  endsequence
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_wait_idle;
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_mem_excl;
    !(memBus.rd && memBus.wr);
  endproperty
  property p_mem_len;
    $fell(memBusy) |-> memLen_q == 5'(cycTime_q) + 5'h01;
  endproperty
  property p_mem_stable;
    memBusy && $past(memBusy) |-> $stable({memBus.addr, memBus.wdata});
  endproperty
  property p_ext_sel;
    s_extDone |=> {extWriteStrobe, extReadStrobe} == 16'h0001 << $past(avs_writedata[3:0]);
  endproperty
  property p_ext_cause;
    (|extWriteStrobe || |extReadStrobe) |->
      $past(avs_write && !avs_waitrequest && avs_address == REG_EXT_CTRL);
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after one wait");
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  a_mem_excl: assert property (p_mem_excl) else $error("memory read and write together");
  a_mem_len: assert property (p_mem_len) else $error("memory cycle length wrong");
  a_mem_stable: assert property (p_mem_stable) else $error("memory address moved");
  a_ext_sel: assert property (p_ext_sel) else $error("wrong external strobe");
  a_ext_cause: assert property (p_ext_cause) else $error("stray external strobe");
endmodule

bind buffer_dma_controller buffer_dma_controller_assertions CHK
(
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .memBus(memBus), .extReadStrobe(extReadStrobe), .extWriteStrobe(extWriteStrobe)
);

//--- dv/dma_client_model.sv
`timescale 1ns/1ps
module dma_client_model
(
  // clock
  input  wire logic                        sys_clk,
  // bench control
  input  wire logic [dma_pkg::NUM_CH-1:0]  go,
  input  wire logic [dma_pkg::NUM_CH-1:0]  reqLow,
  input  wire logic [dma_pkg::NUM_CH-1:0]  ackLow,
  output logic      [dma_pkg::NUM_CH-1:0]  done,
  // client pins
  output logic      [dma_pkg::NUM_CH-1:0]  chReqPin,
  input  wire logic [dma_pkg::NUM_CH-1:0]  chAckPin,
  // buffer memory
  input  wire dma_pkg::memBus_type         memBus,
  output logic      [dma_pkg::BYTE_W-1:0]  memRdData
);
  import dma_pkg::*;
  logic [7:0]        mem [0:65535];
  logic [7:0]        lastByte_q = 8'h00;
  logic [NUM_CH-1:0] reqOn_q = '0;
  logic [NUM_CH-1:0] done_q = '0;
  // pins follow the programmed polarity; idle read bus shows the inverse
  assign chReqPin  = reqOn_q ^ reqLow;
  assign done      = done_q;
  assign memRdData = memBus.rd ? mem[memBus.addr] : ~lastByte_q;
  // memory array and one byte per request pulse, sometimes late to ask;
  // when every channel is told to go at once, all ask on the same edge
  always @(posedge sys_clk)
  begin
    if (memBus.wr) mem[memBus.addr] <= memBus.wdata;
    if (memBus.rd) lastByte_q <= mem[memBus.addr];
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (!go[i])
      begin
        reqOn_q[i] <= 1'b0;
        done_q[i]  <= 1'b0;
      end
      else if (!reqOn_q[i] && !done_q[i] && ((&go) || $urandom_range(3) == 0))
        reqOn_q[i] <= 1'b1;
      else if (reqOn_q[i] && (chAckPin[i] ^ ackLow[i]))
      begin
        reqOn_q[i] <= 1'b0;
        done_q[i]  <= 1'b1;
      end
    end
  end
endmodule

//--- dv/buffer_dma_controller_bench.sv
`timescale 1ns/1ps
module buffer_dma_controller_bench;
  import dma_pkg::*;
  logic                   sys_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [REG_ADDR_W-1:0]  avs_address = '0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [BUS_DATA_W-1:0]  avs_writedata = '0;
  logic [BUS_DATA_W-1:0]  avs_readdata, rd;
  logic                   avs_waitrequest, irq, wrPrev = 1'b0;
  logic [NUM_CH-1:0]      chReqPin, chAckPin, done, go = '0, reqLowV = '0, ackLowV = '0;
  logic [NUM_CH-1:0][7:0] chWriteData = '0;
  logic [BYTE_W-1:0]      chReadData, memRdData;
  memBus_type             memBus;
  logic [EXT_REGS-1:0]    extReadStrobe, extWriteStrobe;
  logic [3:0]             mask;
  logic [7:0]             mCtrl[NUM_CH] = '{default: 8'h00};
  int                     mAddr[NUM_CH], mCnt[NUM_CH] = '{default: 0}, mInit[NUM_CH];
  int                     mIrq = 0, numErrors = 0, checksDone = 0;
  int                     thr[NUM_CH] = '{129, 130, 65535, 0};
  logic [1:0]             order[$];
  buffer_dma_controller DUT
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chReqPin(chReqPin), .chAckPin(chAckPin),
    .chWriteData(chWriteData), .chReadData(chReadData), .memBus(memBus),
    .memRdData(memRdData), .extReadStrobe(extReadStrobe),
    .extWriteStrobe(extWriteStrobe), .irq(irq)
  );
  dma_client_model P
  (
    .sys_clk(sys_clk), .go(go), .reqLow(reqLowV), .ackLow(ackLowV), .done(done),
    .chReqPin(chReqPin), .chAckPin(chAckPin), .memBus(memBus), .memRdData(memRdData)
  );
  // clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // note which channel opens each memory write
  always @(posedge sys_clk)
  begin
    wrPrev <= memBus.wr;
    if (memBus.wr && !wrPrev) order.push_back(memBus.addr[13:12]);
  end
  task automatic endOfTest();
    if (numErrors == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic regWr(input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge sys_clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [31:0] exp, input string what);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge sys_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
    check(what, rd, exp);
  endtask
  function automatic logic [4:0] chReg(input logic [1:0] ch, input logic [1:0] ofs);
    return REG_CH_BASE + 5'({ch, ofs});
  endfunction
  function automatic logic [31:0] expStatus();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
    begin
      s[i]     = mCtrl[i][0];
      s[i + 4] = mCnt[i] > 129;
    end
    return 32'(s);
  endfunction
  // disable, set client polarity, then program and read back a channel
  task automatic setup(input logic [1:0] ch, input int a, input int c, input logic [7:0] ct);
    regWr(chReg(ch, CH_CTRL_OFS), 32'h0);
    reqLowV[ch] <= ct[4];
    ackLowV[ch] <= ct[5];
    mAddr[ch] = a;
    mCnt[ch]  = c;
    mInit[ch] = c;
    mCtrl[ch] = ct;
    regWr(chReg(ch, CH_ADDR_OFS), 32'(a));
    regWr(chReg(ch, CH_COUNT_OFS), 32'(c));
    regWr(chReg(ch, CH_CTRL_OFS), 32'(ct));
    rdChk(chReg(ch, CH_ADDR_OFS), 32'(a), "address");
    rdChk(chReg(ch, CH_COUNT_OFS), 32'(c), "count");
    rdChk(chReg(ch, CH_CTRL_OFS), 32'(ct), "control");
  endtask
  // one byte through the client handshake, then the model steps
  task automatic xfer(input logic [1:0] ch);
    logic [7:0]  b;
    logic [15:0] a;
    b = 8'($urandom);
    a = 16'(mAddr[ch]);
    if (!mCtrl[ch][1]) P.mem[a] = b;
    chWriteData[ch] <= b;
    go[ch] <= 1'b1;
    @(posedge sys_clk iff done[ch]);
    go[ch] <= 1'b0;
    @(posedge sys_clk iff chAckPin[ch] === mCtrl[ch][5]);
    if (mCtrl[ch][1]) check("memory byte", P.mem[a], b);
    else check("read byte", chReadData, b);
    mAddr[ch] = (mAddr[ch] + 1) % 65536;
    mCnt[ch]--;
    if (mCnt[ch] == 0 && mCtrl[ch][3]) mIrq |= 1 << ch;
    if (mCnt[ch] == 0 && mCtrl[ch][2]) mCnt[ch] = mInit[ch];
  endtask
  // watchdog
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    numErrors++;
    endOfTest();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'hd78d));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdChk(REG_CH_STATUS, 32'h0, "status");
    rdChk(REG_CYCLE_TIME, 32'h0, "write only");
    rdChk(REG_IRQ_MASK, 32'h0, "mask");
    rdChk(5'h1F, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++) regWr(REG_EXT_CTRL, 32'(i));
    for (int i = 0; i < NUM_CH; i++) setup(2'(i), i << 12, thr[i], {7'h00, i[0]});
    rdChk(REG_CH_STATUS, expStatus(), "status");
    for (int r = 0; r < 4; r++)
    begin
      regWr(REG_CYCLE_TIME, 32'($urandom_range(15)));
      for (int i = 0; i < NUM_CH; i++)
      begin
        setup(2'(i), r == 0 ? 65535 : $urandom_range(65535), $urandom_range(3, 1),
              {1'b0, 6'($urandom), 1'b1});
        repeat (mCnt[i] + int'(mCtrl[i][2])) xfer(2'(i));
        rdChk(chReg(2'(i), CH_ADDR_OFS), 32'(mAddr[i]), "address");
        rdChk(chReg(2'(i), CH_COUNT_OFS), 32'(mCnt[i]), "count");
      end
      rdChk(REG_CH_STATUS, expStatus(), "status");
      mask = 4'($urandom);
      regWr(REG_IRQ_MASK, 32'(mask));
      rdChk(REG_IRQ_MASK, 32'(mask), "mask");
      check("irq", irq, 32'(|(mIrq[3:0] & mask)));
      rdChk(REG_IRQ_STATUS, 32'(mIrq), "irq status");
      mIrq = 0;
      @(posedge sys_clk);
      check("irq cleared", irq, 32'h0);
    end
    setup(2'd0, 16'h0100, 5, 8'h02);
    go[0] <= 1'b1;
    repeat (30) @(posedge sys_clk);
    go[0] <= 1'b0;
    rdChk(chReg(2'd0, CH_COUNT_OFS), 32'd5, "disabled count");
    regWr(REG_CYCLE_TIME, 32'h80);
    @(posedge sys_clk);
    check("irq polarity", irq, 32'h1);
    regWr(REG_CYCLE_TIME, 32'h0);
    @(posedge sys_clk);
    check("irq polarity", irq, 32'h0);
    for (int i = 0; i < NUM_CH; i++) setup(2'(i), i << 12, 1, 8'h03);
    order.delete();
    fork
      xfer(2'd3);
      xfer(2'd2);
      xfer(2'd1);
      xfer(2'd0);
    join
    check("grants", order.size(), 32'd4);
    foreach (order[i]) check("grant order", order[i], 32'(i));
    endOfTest();
  end
endmodule
